// [design/pmf_consts.svh]
// Constants of the PTP message forwarding filter.
// Assumes inclusion by bare name from design files.
`ifndef PMF_CONSTS_SVH
`define PMF_CONSTS_SVH

// Register indices; byte address is four times the index
`define PMF_IDX_CFG1     16'h0514
`define PMF_IDX_POLICY   16'h0516
`define PMF_IDX_DOMAIN   16'h0518
`define PMF_IDX_MASTER   16'h05F0
`define PMF_IDX_STATUS   16'h05F1

// Reset values and writable masks
`define PMF_CFG1_RST     16'h0039
`define PMF_CFG1_WMASK   16'h007E
`define PMF_POLICY_RST   16'h1004
`define PMF_POLICY_WMASK 16'h1FFF
`define PMF_DOMAIN_RST   16'h0200
`define PMF_DOMAIN_WMASK 16'h0FFF

// Field positions, message config 1
`define PMF_B_MODE_EN    6
`define PMF_B_DET_L2     5
`define PMF_B_DET_V4     4
`define PMF_B_DET_V6     3
// Field positions, policy register
`define PMF_B_UNICAST    12
`define PMF_B_ALT_MST    11
`define PMF_B_PRIO_ALL   10
`define PMF_B_ASC_SYNC   9
`define PMF_B_ASC_DLY    8
`define PMF_B_ASC_PDLY   7
`define PMF_B_AUTO_DROP  5
`define PMF_B_DOM_CHK    4
`define PMF_B_CSUM_GEN   2

// UDP ports of PTP event and general traffic
`define PMF_UDP_EVENT    16'h013F
`define PMF_UDP_GENERAL  16'h0140

// Association key: domain, sequence, source port identity
`define PMF_SRC_W        80
`define PMF_KEY_W        104
`define PMF_ASSOC_N      3

`endif

// [design/pmf_pkg.sv]
// Types of the PTP message forwarding filter.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pmf_pkg;
    typedef enum logic [3:0]
    {
        PMF_SYNC       = 4'h0,
        PMF_DELAY_REQ  = 4'h1,
        PMF_PDLY_REQ   = 4'h2,
        PMF_PDLY_RESP  = 4'h3,
        PMF_FOLLOW_UP  = 4'h8,
        PMF_DELAY_RESP = 4'h9,
        PMF_PDLY_FU    = 4'hA
    } pmf_msg_e;
    typedef enum logic [1:0]
    {
        PMF_TR_L2 = 2'h0,
        PMF_TR_V4 = 2'h1,
        PMF_TR_V6 = 2'h2
    } pmf_tr_e;
    typedef logic [1:0] pmf_kind_t;
endpackage : pmf_pkg
`default_nettype wire

// [design/pmf_assoc.sv]
// Association store: one request key per kind (Sync, Delay_Req, Pdelay_Req).
// Assumes the caller qualifies store and lookup with its own frame strobe.
`include "pmf_consts.svh"
`default_nettype none
module pmf_assoc
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Store a request key
    input  wire logic                   store_en,
    input  wire pmf_pkg::pmf_kind_t     store_kind,
    // Look up a follower key
    input  wire pmf_pkg::pmf_kind_t     look_kind,
    input  wire logic [`PMF_KEY_W-1:0]  key,
    output logic                        hit
);
    logic [`PMF_KEY_W-1:0]   key_q [`PMF_ASSOC_N];
    logic [`PMF_ASSOC_N-1:0] vld_q;
    logic [`PMF_ASSOC_N-1:0] eq;

    genvar gi;
    generate
        for (gi = 0; gi < `PMF_ASSOC_N; gi++)
        begin : g_ent
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    key_q[gi] <= '0;
                    vld_q[gi] <= 1'b0;
                end
                else if (store_en && store_kind == pmf_pkg::pmf_kind_t'(gi))
                begin
                    key_q[gi] <= key;
                    vld_q[gi] <= 1'b1;
                end
            end
            assign eq[gi] = vld_q[gi] && key_q[gi] == key;
        end
    endgenerate

    // Only the newest request per kind is kept; older ones never pair
    always_comb
    begin
        hit = 1'b0;
        if (look_kind < pmf_pkg::pmf_kind_t'(`PMF_ASSOC_N))
            hit = eq[look_kind];
    end
endmodule : pmf_assoc
`default_nettype wire

// [design/pmf_top.sv]
// PTP message forwarding filter: per-frame decision and egress checksum.
// Assumes a frame classifier ahead that gives one descriptor per frame
// as a one-cycle strobe, and an APB master for configuration.
// Function
// - With unicast enabled, UDP port 319 or 320 to a non-reserved address is unicast PTP via table lookup.
// - With unicast disabled only multicast PTP is recognized; unicast defaults to enabled.
// - With alternate master on, same-domain Sync/Delay_Req from the active master go to the host and non-host ports.
// - With alternate master off, those frames go to neither the host nor other ports; other domains go to both.
// - Priority set sends all PTP to the top queue, clear sends only event messages.
// - With Sync association on, a Follow_Up reaches the host only if it matches a Sync.
// - With delay association on, a Delay_Resp reaches the host only if it matches a Delay_Req.
// - With peer association on, Pdelay responses reach the host only if they match a Pdelay_Req.
// - With auto drop on, Sync, Follow_Up and Delay_Req drop while no best master is known.
// - With domain check on, matching domains go to the host and others are dropped.
// - With checksum generation on, modified egress frames get a recomputed UDP checksum; default on.
// - With checksum generation off, modified IPv4 egress frames carry a zero UDP checksum.
// - An incoming IPv4/UDP checksum of zero stays zero.
// - IPv6/UDP checksums of modified frames are always updated.
// - An eight-bit configured domain value, reset zero, is held for the domain compare.
// - A global PTP mode enable, reset off, gates PTP recognition and the forwarding decision; the egress checksum path ignores it.
`include "pmf_consts.svh"
`default_nettype none
module pmf_top
(
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    // APB slave
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [15:0]            PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    // Frame descriptor
    input  wire logic                   FRM_VALID,
    input  wire logic                   FRM_FROM_HOST,
    input  wire logic [1:0]             FRM_TRANSPORT,
    input  wire logic                   FRM_RSV_ADDR,
    input  wire logic [15:0]            FRM_UDP_DPORT,
    input  wire logic [3:0]             FRM_MSG_TYPE,
    input  wire logic [7:0]             FRM_DOMAIN,
    input  wire logic [15:0]            FRM_SEQ_ID,
    input  wire logic [`PMF_SRC_W-1:0]  FRM_SRC_PORT_ID,
    input  wire logic                   FRM_ACT_MASTER,
    input  wire logic                   FRM_MODIFIED,
    input  wire logic [15:0]            FRM_CSUM_IN,
    input  wire logic [15:0]            FRM_CSUM_NEW,
    // Decision
    output logic                        DEC_VALID,
    output logic                        DEC_IS_PTP,
    output logic                        DEC_LOOKUP,
    output logic                        DEC_TO_HOST,
    output logic                        DEC_TO_PORTS,
    output logic                        DEC_DROP,
    output logic                        DEC_HI_PRIO,
    output logic      [15:0]            DEC_CSUM
);
    logic [15:0] cfg1_q;
    logic [15:0] policy_q;
    logic [15:0] domain_q;
    logic        bmc_known_q;
    logic [15:0] drop_cnt_q;
    logic [15:0] idx;
    logic        hit_reg;
    logic [31:0] rd_d;
    logic        wr_en;
    logic        is_ptp;
    logic        uc;
    logic        tr_ok;
    logic        udp;
    logic        to_host;
    logic        to_ports;
    logic        drop;
    logic        hi_prio;
    logic [15:0] csum;
    logic        dom_eq;
    logic        store_en;
    logic        asc_hit;
    pmf_pkg::pmf_kind_t store_kind;
    pmf_pkg::pmf_kind_t look_kind;
    pmf_pkg::pmf_msg_e  ty;

    // Register access
    assign idx     = {2'h0, PADDR[15:2]};
    assign hit_reg = idx == `PMF_IDX_CFG1 || idx == `PMF_IDX_POLICY || idx == `PMF_IDX_DOMAIN
                     || idx == `PMF_IDX_MASTER || idx == `PMF_IDX_STATUS;
    assign wr_en   = PSEL && PENABLE && PREADY && PWRITE && hit_reg;

    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (idx)
            `PMF_IDX_CFG1:   rd_d[15:0] = cfg1_q;
            `PMF_IDX_POLICY: rd_d[15:0] = policy_q;
            `PMF_IDX_DOMAIN: rd_d[15:0] = domain_q;
            `PMF_IDX_MASTER: rd_d[0]    = bmc_known_q;
            `PMF_IDX_STATUS: rd_d[15:0] = drop_cnt_q;
            default:         rd_d = 32'h0000_0000;
        endcase
    end

    // Zero wait states: ready rises in the first access cycle
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit_reg;
            PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rd_d : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cfg1_q      <= `PMF_CFG1_RST;
            policy_q    <= `PMF_POLICY_RST;
            domain_q    <= `PMF_DOMAIN_RST;
            bmc_known_q <= 1'b0;
        end
        else if (wr_en)
        begin
            if (idx == `PMF_IDX_CFG1)
                cfg1_q <= (cfg1_q & ~`PMF_CFG1_WMASK) | (PWDATA[15:0] & `PMF_CFG1_WMASK);
            if (idx == `PMF_IDX_POLICY)
                policy_q <= PWDATA[15:0] & `PMF_POLICY_WMASK;
            if (idx == `PMF_IDX_DOMAIN)
                domain_q <= PWDATA[15:0] & `PMF_DOMAIN_WMASK;
            if (idx == `PMF_IDX_MASTER)
                bmc_known_q <= PWDATA[0];
        end
    end

    // Frame decision
    assign ty     = pmf_pkg::pmf_msg_e'(FRM_MSG_TYPE);
    assign dom_eq = FRM_DOMAIN == domain_q[7:0];
    assign udp    = FRM_TRANSPORT == pmf_pkg::PMF_TR_V4 || FRM_TRANSPORT == pmf_pkg::PMF_TR_V6;

    always_comb
    begin
        unique case (FRM_TRANSPORT)
            pmf_pkg::PMF_TR_L2: tr_ok = cfg1_q[`PMF_B_DET_L2];
            pmf_pkg::PMF_TR_V4: tr_ok = cfg1_q[`PMF_B_DET_V4];
            pmf_pkg::PMF_TR_V6: tr_ok = cfg1_q[`PMF_B_DET_V6];
            default:            tr_ok = 1'b0;
        endcase
    end

    // Unicast needs UDP, a PTP port and a non-reserved address
    assign uc = policy_q[`PMF_B_UNICAST] && udp && !FRM_RSV_ADDR
                && (FRM_UDP_DPORT == `PMF_UDP_EVENT || FRM_UDP_DPORT == `PMF_UDP_GENERAL);
    assign is_ptp = cfg1_q[`PMF_B_MODE_EN] && tr_ok && (FRM_RSV_ADDR || uc);

    always_comb
    begin
        look_kind  = 2'h3;
        store_kind = 2'h3;
        unique case (ty)
            pmf_pkg::PMF_SYNC:       store_kind = 2'h0;
            pmf_pkg::PMF_DELAY_REQ:  store_kind = 2'h1;
            pmf_pkg::PMF_PDLY_REQ:   store_kind = 2'h2;
            pmf_pkg::PMF_FOLLOW_UP:  look_kind  = 2'h0;
            pmf_pkg::PMF_DELAY_RESP: look_kind  = 2'h1;
            pmf_pkg::PMF_PDLY_RESP,
            pmf_pkg::PMF_PDLY_FU:    look_kind  = 2'h2;
            default:                 look_kind  = 2'h3;
        endcase
    end

    always_comb
    begin
        // Multicast PTP reaches the host and the other ports by default
        to_host  = is_ptp && FRM_RSV_ADDR && !FRM_FROM_HOST;
        to_ports = is_ptp && FRM_RSV_ADDR;
        drop     = 1'b0;
        if ((ty == pmf_pkg::PMF_SYNC || ty == pmf_pkg::PMF_DELAY_REQ) && !FRM_FROM_HOST
            && FRM_ACT_MASTER && dom_eq)
        begin
            if (policy_q[`PMF_B_ALT_MST])
                to_ports = to_ports;
            else
            begin
                to_host  = 1'b0;
                to_ports = 1'b0;
            end
        end
        if (ty == pmf_pkg::PMF_FOLLOW_UP && policy_q[`PMF_B_ASC_SYNC])
            to_host = to_host && asc_hit;
        if (ty == pmf_pkg::PMF_DELAY_RESP && policy_q[`PMF_B_ASC_DLY])
            to_host = to_host && asc_hit;
        if ((ty == pmf_pkg::PMF_PDLY_RESP || ty == pmf_pkg::PMF_PDLY_FU) && policy_q[`PMF_B_ASC_PDLY])
            to_host = to_host && asc_hit;
        if (policy_q[`PMF_B_AUTO_DROP] && !bmc_known_q && (ty == pmf_pkg::PMF_SYNC
            || ty == pmf_pkg::PMF_FOLLOW_UP || ty == pmf_pkg::PMF_DELAY_REQ))
            drop = is_ptp;
        if (policy_q[`PMF_B_DOM_CHK] && !dom_eq)
            drop = is_ptp;
        if (drop)
        begin
            to_host  = 1'b0;
            to_ports = 1'b0;
        end
    end

    assign hi_prio  = is_ptp && (policy_q[`PMF_B_PRIO_ALL] || !FRM_MSG_TYPE[3]);
    assign store_en = FRM_VALID && is_ptp && !drop && store_kind != 2'h3;

    always_comb
    begin
        csum = FRM_CSUM_IN;
        if (FRM_MODIFIED)
        begin
            if (FRM_TRANSPORT == pmf_pkg::PMF_TR_V6)
                csum = FRM_CSUM_NEW;
            else if (FRM_TRANSPORT == pmf_pkg::PMF_TR_V4)
            begin
                if (FRM_CSUM_IN == 16'h0000)
                    csum = 16'h0000;
                else if (policy_q[`PMF_B_CSUM_GEN])
                    csum = FRM_CSUM_NEW;
                else
                    csum = 16'h0000;
            end
        end
    end

    pmf_assoc u_assoc
    (
        .clk        (CLK),
        .rst_n      (RESET_N),
        .store_en   (store_en),
        .store_kind (store_kind),
        .look_kind  (look_kind),
        .key        ({FRM_DOMAIN, FRM_SEQ_ID, FRM_SRC_PORT_ID}),
        .hit        (asc_hit)
    );

    // Decision outputs other than DEC_VALID hold the last decision until the next frame
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            DEC_VALID    <= 1'b0;
            DEC_IS_PTP   <= 1'b0;
            DEC_LOOKUP   <= 1'b0;
            DEC_TO_HOST  <= 1'b0;
            DEC_TO_PORTS <= 1'b0;
            DEC_DROP     <= 1'b0;
            DEC_HI_PRIO  <= 1'b0;
            DEC_CSUM     <= 16'h0000;
        end
        else
        begin
            DEC_VALID <= FRM_VALID;
            if (FRM_VALID)
            begin
                DEC_IS_PTP   <= is_ptp;
                DEC_LOOKUP   <= is_ptp && uc;
                DEC_TO_HOST  <= to_host;
                DEC_TO_PORTS <= to_ports;
                DEC_DROP     <= drop;
                DEC_HI_PRIO  <= hi_prio;
                DEC_CSUM     <= csum;
            end
        end
    end

    // Saturating drop counter; wrap would hide a storm
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            drop_cnt_q <= 16'h0000;
        else if (FRM_VALID && drop && drop_cnt_q != 16'hFFFF)
            drop_cnt_q <= drop_cnt_q + 16'h0001;
    end

    property p_uni;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && is_ptp && uc |=> DEC_LOOKUP && DEC_IS_PTP;
    endproperty
    a_uni: assert property (p_uni) else $error("unicast not sent to lookup");

    property p_uni_off;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && !policy_q[`PMF_B_UNICAST] && !FRM_RSV_ADDR |=> !DEC_IS_PTP;
    endproperty
    a_uni_off: assert property (p_uni_off) else $error("unicast seen while disabled");

    property p_alt_off;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && !policy_q[`PMF_B_ALT_MST] && ty == pmf_pkg::PMF_SYNC && !FRM_FROM_HOST
        && FRM_ACT_MASTER && dom_eq |=> !DEC_TO_HOST;
    endproperty
    a_alt_off: assert property (p_alt_off) else $error("master sync reached host");

    property p_prio;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && is_ptp |=> DEC_HI_PRIO == ($past(policy_q[`PMF_B_PRIO_ALL]) || !$past(FRM_MSG_TYPE[3]));
    endproperty
    a_prio: assert property (p_prio) else $error("wrong queue priority");

    property p_bmc;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && is_ptp && policy_q[`PMF_B_AUTO_DROP] && !bmc_known_q
        && ty == pmf_pkg::PMF_FOLLOW_UP |=> DEC_DROP && !DEC_TO_HOST;
    endproperty
    a_bmc: assert property (p_bmc) else $error("follow up kept without master");

    property p_dom;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && is_ptp && policy_q[`PMF_B_DOM_CHK] && !dom_eq |=> DEC_DROP ##1 drop_cnt_q != 16'h0000;
    endproperty
    a_dom: assert property (p_dom) else $error("foreign domain not dropped");

    property p_csum_zero;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && FRM_TRANSPORT == pmf_pkg::PMF_TR_V4 && FRM_CSUM_IN == 16'h0000 |=> DEC_CSUM == 16'h0000;
    endproperty
    a_csum_zero: assert property (p_csum_zero) else $error("zero checksum altered");

    property p_csum_v6;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && FRM_MODIFIED && FRM_TRANSPORT == pmf_pkg::PMF_TR_V6 |=> DEC_CSUM == $past(FRM_CSUM_NEW);
    endproperty
    a_csum_v6: assert property (p_csum_v6) else $error("ipv6 checksum not updated");

    property p_csum_off;
        @(posedge CLK) disable iff (!RESET_N)
        FRM_VALID && FRM_MODIFIED && FRM_TRANSPORT == pmf_pkg::PMF_TR_V4
        && !policy_q[`PMF_B_CSUM_GEN] |=> DEC_CSUM == 16'h0000;
    endproperty
    a_csum_off: assert property (p_csum_off) else $error("checksum not cleared");

    property p_rsv;
        @(posedge CLK) disable iff (!RESET_N)
        PSEL && !PENABLE && !PWRITE && idx == `PMF_IDX_POLICY |=> PREADY && PRDATA[31:13] == 19'h00000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved policy bits nonzero");

    c_uni: cover property (@(posedge CLK) disable iff (!RESET_N) FRM_VALID && uc && is_ptp);
    c_asc: cover property (@(posedge CLK) disable iff (!RESET_N) FRM_VALID && look_kind == 2'h0 && asc_hit);
    c_drop: cover property (@(posedge CLK) disable iff (!RESET_N) FRM_VALID && drop);
    c_wr: cover property (@(posedge CLK) disable iff (!RESET_N) wr_en && idx == `PMF_IDX_POLICY);
endmodule : pmf_top
`default_nettype wire

// [tb/pmf_node_model.sv]
// Frame source model standing for the PTP nodes on the switch ports.
// Assumes the bench calls send between clock edges and waits for each decision.
`default_nettype none
module pmf_node_model
(
    // Clock
    input  wire logic        clk,
    // Frame descriptor
    output logic             frm_valid,
    output logic             frm_from_host,
    output logic [1:0]       frm_transport,
    output logic             frm_rsv_addr,
    output logic [15:0]      frm_udp_dport,
    output logic [3:0]       frm_msg_type,
    output logic [7:0]       frm_domain,
    output logic [15:0]      frm_seq_id,
    output logic [79:0]      frm_src_port_id,
    output logic             frm_act_master,
    output logic             frm_modified,
    output logic [15:0]      frm_csum_in,
    output logic [15:0]      frm_csum_new
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [161:0] fld_q = '0;
    assign {frm_from_host, frm_transport, frm_rsv_addr, frm_udp_dport, frm_msg_type, frm_domain, frm_seq_id,
            frm_src_port_id, frm_act_master, frm_modified, frm_csum_in, frm_csum_new} = fld_q;
    initial frm_valid = 1'b0;

    task automatic send(input logic h, input logic [1:0] tr, input logic rsv, input logic [15:0] dp,
                        input logic [3:0] msg, input logic [7:0] dom, input logic [15:0] seq, input logic act,
                        input logic md, input logic [15:0] ci, input logic [15:0] cn);
        @(posedge clk);
        fld_q     <= {h, tr, rsv, dp, msg, dom, seq, {5{seq}}, act, md, ci, cn};
        frm_valid <= 1'b1;
        @(posedge clk);
        frm_valid <= 1'b0;
        // Fields are meaningless outside the strobe, so they never show the last frame
        fld_q     <= ~fld_q;
    endtask : send
endmodule : pmf_node_model
`default_nettype wire

// [tb/pmf_top_bench.sv]
// Self-checking bench for the PTP message forwarding filter.
// Polls APB ready with no wait-state count and assumes a decision one cycle after each frame strobe.
`include "pmf_consts.svh"
`default_nettype none
module pmf_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, fv, fh, frsv, fact, fmod;
    logic [1:0] ftr;
    logic [15:0] fdp, fseq, fci, fcn, dcs;
    logic [3:0] fmsg;
    logic [7:0] fdom;
    logic [79:0] fsrc;
    logic dv, dptp, dlk, dhost, dports, ddrop, dhi;
    logic g_h = 0, g_rsv = 1, g_act = 0, g_mod = 0;
    logic [1:0] g_tr = 0;
    logic [15:0] g_dp = 0, g_ci = 0, g_cn = 0;
    int err_total = 0, checks_done = 0;

    initial forever #5 clk = ~clk;

    pmf_node_model u_node (.clk(clk), .frm_valid(fv), .frm_from_host(fh), .frm_transport(ftr),
        .frm_rsv_addr(frsv), .frm_udp_dport(fdp), .frm_msg_type(fmsg), .frm_domain(fdom), .frm_seq_id(fseq),
        .frm_src_port_id(fsrc), .frm_act_master(fact), .frm_modified(fmod), .frm_csum_in(fci),
        .frm_csum_new(fcn));
    pmf_top u_dut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FRM_VALID(fv), .FRM_FROM_HOST(fh), .FRM_TRANSPORT(ftr), .FRM_RSV_ADDR(frsv), .FRM_UDP_DPORT(fdp),
        .FRM_MSG_TYPE(fmsg), .FRM_DOMAIN(fdom), .FRM_SEQ_ID(fseq), .FRM_SRC_PORT_ID(fsrc),
        .FRM_ACT_MASTER(fact), .FRM_MODIFIED(fmod), .FRM_CSUM_IN(fci), .FRM_CSUM_NEW(fcn), .DEC_VALID(dv),
        .DEC_IS_PTP(dptp), .DEC_LOOKUP(dlk), .DEC_TO_HOST(dhost), .DEC_TO_PORTS(dports), .DEC_DROP(ddrop),
        .DEC_HI_PRIO(dhi), .DEC_CSUM(dcs));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_dec(input logic [6:0] exp, input logic [6:0] msk);
        logic [6:0] got;
        got = {dv, dptp, dlk, dhost, dports, ddrop, dhi};
        checks_done++;
        if ((got & msk) !== (exp & msk))
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got & msk, exp & msk);
        end
    endtask : chk_dec

    // Setup cycle, then access held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= idx << 2;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // No wait-state count is assumed; only the watchdog ends a hang
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, idx, d, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic exp_er);
        logic [31:0] rd;
        logic er;
        apb(1'b0, idx, 32'h0, rd, er);
        chk_word(rd, exp);
        chk_word({31'h0, er}, {31'h0, exp_er});
    endtask : rd_chk

    // Decision bits: is_ptp, lookup, to_host, to_ports, drop, hi_prio
    task automatic frm(input logic [3:0] msg, input logic [7:0] dom, input logic [15:0] seq,
                       input logic [5:0] exp, input logic [5:0] msk = 6'h3F);
        u_node.send(g_h, g_tr, g_rsv, g_dp, msg, dom, seq, g_act, g_mod, g_ci, g_cn);
        #1;
        chk_dec({1'b1, exp}, {1'b1, msk});
    endtask : frm

    logic [3:0] req_t [4] = '{4'h0, 4'h1, 4'h2, 4'h2};
    logic [3:0] fol_t [4] = '{4'h8, 4'h9, 4'h3, 4'hA};

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`PMF_IDX_POLICY, 32'h1004, 1'b0);
        rd_chk(`PMF_IDX_DOMAIN, 32'h0200, 1'b0);
        rd_chk(`PMF_IDX_CFG1, 32'h0039, 1'b0);
        rd_chk(16'h0600, 32'h0, 1'b1);
        wr(`PMF_IDX_POLICY, 32'hFFFF);
        rd_chk(`PMF_IDX_POLICY, 32'h1FFF, 1'b0);
        wr(`PMF_IDX_POLICY, 32'h1004);
        frm(4'h0, 8'h00, 16'h1, 6'h00, 6'h20);
        wr(`PMF_IDX_CFG1, 32'h0079);
        frm(4'h0, 8'h00, 16'h1, 6'b101101);
        frm(4'h8, 8'h00, 16'h1, 6'b101100);
        wr(`PMF_IDX_POLICY, 32'h1404);
        frm(4'h8, 8'h00, 16'h1, 6'b101101);
        g_tr = 2'h1;
        g_rsv = 1'b0;
        g_dp = 16'd319;
        frm(4'h0, 8'h00, 16'h2, 6'b110001);
        g_dp = 16'd320;
        frm(4'h0, 8'h00, 16'h2, 6'b110001);
        wr(`PMF_IDX_POLICY, 32'h0004);
        frm(4'h0, 8'h00, 16'h2, 6'h00, 6'h20);
        g_rsv = 1'b1;
        g_act = 1'b1;
        wr(`PMF_IDX_POLICY, 32'h1004);
        frm(4'h0, 8'h00, 16'h3, 6'b100001);
        frm(4'h1, 8'h07, 16'h3, 6'b101101);
        wr(`PMF_IDX_POLICY, 32'h1804);
        frm(4'h1, 8'h00, 16'h3, 6'b101101);
        g_act = 1'b0;
        wr(`PMF_IDX_POLICY, 32'h1384);
        for (int i = 0; i < 4; i++)
        begin
            frm(req_t[i], 8'h03, 16'h40 + 16'(i), 6'b101101);
            frm(fol_t[i], 8'h03, 16'h40 + 16'(i), {4'b1011, 1'b0, fol_t[i] < 4'h8});
            frm(fol_t[i], 8'h03, 16'h50 + 16'(i), {4'b1001, 1'b0, fol_t[i] < 4'h8});
        end
        wr(`PMF_IDX_POLICY, 32'h1024);
        frm(4'h0, 8'h00, 16'h4, 6'b100011);
        frm(4'h8, 8'h00, 16'h4, 6'b100010);
        frm(4'h2, 8'h00, 16'h4, 6'b101101);
        wr(`PMF_IDX_MASTER, 32'h1);
        frm(4'h0, 8'h00, 16'h4, 6'b101101);
        wr(`PMF_IDX_DOMAIN, 32'h0205);
        rd_chk(`PMF_IDX_DOMAIN, 32'h0205, 1'b0);
        wr(`PMF_IDX_POLICY, 32'h1014);
        frm(4'h0, 8'h05, 16'h5, 6'b101101);
        frm(4'h0, 8'h06, 16'h5, 6'b100011);
        wr(`PMF_IDX_POLICY, 32'h1004);
        g_dp = 16'd319;
        g_mod = 1'b1;
        g_ci = 16'h1234;
        g_cn = 16'hABCD;
        frm(4'h0, 8'h05, 16'h6, 6'b101101);
        chk_word({16'h0, dcs}, 32'hABCD);
        g_ci = 16'h0000;
        frm(4'h0, 8'h05, 16'h6, 6'b101101);
        chk_word({16'h0, dcs}, 32'h0000);
        g_ci = 16'h1234;
        wr(`PMF_IDX_POLICY, 32'h1000);
        frm(4'h0, 8'h05, 16'h6, 6'b101101);
        chk_word({16'h0, dcs}, 32'h0000);
        g_tr = 2'h2;
        frm(4'h0, 8'h05, 16'h6, 6'b101101);
        chk_word({16'h0, dcs}, 32'hABCD);
        // Host-port ingress goes to the other ports but never back to the host
        g_h = 1'b1;
        frm(4'h0, 8'h05, 16'h7, 6'b100101);
        chk_word({16'h0, dcs}, 32'hABCD);
        rd_chk(`PMF_IDX_MASTER, 32'h1, 1'b0);
        // Two frames dropped without a master, one for a foreign domain
        rd_chk(`PMF_IDX_STATUS, 32'h3, 1'b0);
        summarize();
    end

    // Whole run needs under two hundred cycles
    initial
    begin
        #300us;
        err_total++;
        summarize();
    end
endmodule : pmf_top_bench
`default_nettype wire
